// ===== verilog/rcr_pkg.sv
// Package for the rail control register bank: offsets, field layout,
// factory reset images and the factory sleep pin assignment.
// Assumes an I2C engine outside presents decoded byte accesses.
package rcr_pkg;

	// Byte offsets of the three control registers
	localparam logic [7:0] RCR_CONV5_OFFSET = 8'h26;
	localparam logic [7:0] RCR_CONV6_OFFSET = 8'h27;
	localparam logic [7:0] RCR_LIN2_OFFSET  = 8'h28;

	// Field positions inside the control registers; the mode bit is on the converters only
	localparam int RCR_RUN_BIT       = 0;
	localparam int RCR_MODE_BIT      = 1;
	localparam int RCR_SLEEP_SEL_LO  = 4;
	localparam int RCR_SLEEP_SEL_HI  = 5;
	localparam int RCR_STORED_WIDTH  = 6;

	// Sleep select encodings; 01 and 10 are reserved
	localparam logic [1:0] RCR_SLEEP_OFF = 2'h0;
	localparam logic [1:0] RCR_SLEEP_ON  = 2'h3;

	// Factory images of the writable bits 5:0 (bits 7:6 always zero)
	localparam logic [5:0] RCR_CONV5_RESET = 6'h0F;
	localparam logic [5:0] RCR_CONV6_RESET = 6'h0D;
	localparam logic [5:0] RCR_LIN2_RESET  = 6'h0C;

	// Value returned for offsets outside this bank
	localparam logic [7:0] RCR_UNMAPPED_DATA = 8'h00;

	// Index of each sleep-capable control input inside the pin bus
	localparam int RCR_PIN_THREE = 2;
	localparam int RCR_PIN_SIX   = 5;

	// Factory sleep pin choice per rail: 0 picks input three, 1 input six
	localparam logic RCR_CONV5_PIN_SEL = 1'b0;
	localparam logic RCR_CONV6_PIN_SEL = 1'b1;
	localparam logic RCR_LIN2_PIN_SEL  = 1'b0;

	// Voltage code width shared with the voltage registers outside
	localparam int RCR_CODE_WIDTH = 7;

endpackage

// ===== verilog/rcr_rail_out.sv
// One rail's output stage: enable gating and voltage code selection.
// Assumes pins are synchronous to clk and codes come from registers outside.
`timescale 1ns/10ps
module rcr_rail_out
	import rcr_pkg::*;
#(
	parameter logic PIN_SEL = 1'b0 // Factory sleep pin choice
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic [1:0]                sleepSelect,
	input  wire logic                      runAllow,
	input  wire logic                      pinRequest,
	input  wire logic                      sleepPinThree,
	input  wire logic                      sleepPinSix,
	input  wire logic [RCR_CODE_WIDTH-1:0] normalCode,
	input  wire logic [RCR_CODE_WIDTH-1:0] sleepCode,
	output logic                           railEnable_q,
	output logic                           inSleep_q,
	output logic [RCR_CODE_WIDTH-1:0]      activeCode_q
);

	// Sleep applies only with the full 11 code and a low pin; reserved
	// codes behave as off so a stray write cannot half-enable sleep
	function automatic logic sleepActive(input logic [1:0] sel, input logic pin);
		sleepActive = (sel == RCR_SLEEP_ON) && !pin;
	endfunction

	logic                      pinLevel;  // Level of the factory-chosen pin
	logic                      sleepNow;  // Sleep code wanted this cycle
	logic [RCR_CODE_WIDTH-1:0] codeNext;  // Code to present next cycle
	logic                      enableNext; // Enable to present next cycle

	// Pin fixed at build time, software cannot move it
	assign pinLevel   = PIN_SEL ? sleepPinSix : sleepPinThree;
	assign sleepNow   = sleepActive(sleepSelect, pinLevel);
	assign codeNext   = sleepNow ? sleepCode : normalCode;
	// Register bit low overrides any pin request
	assign enableNext = runAllow & pinRequest;

	// Outputs registered so the power stage sees glitch-free levels
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			railEnable_q <= 1'b0;
			inSleep_q    <= 1'b0;
			activeCode_q <= '0;
		end else begin
			railEnable_q <= enableNext;
			inSleep_q    <= sleepNow;
			activeCode_q <= codeNext;
		end
	end

endmodule

// ===== verilog/rcr_rail_control.sv
// Control register bank for converter five, converter six and linear
// regulator two, plus the per-rail output stages that it steers.
// Assumes the I2C engine outside delivers one-cycle read and write
// strobes with a byte offset, and that pins are synchronous to clk.
// Reserved bits are stored as written; legal host code keeps them fixed.
`timescale 1ns/10ps
module rcr_rail_control
	import rcr_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Decoded byte access from the I2C engine
	input  wire logic [7:0]                regAddr,
	input  wire logic [7:0]                regWrData,
	input  wire logic                      regWrEn,
	input  wire logic                      regRdEn,
	output logic [7:0]                     regRdData_q,
	output logic                           regRdValid_q,
	output logic                           regHit,
	// The six control inputs, sleep pins among them
	input  wire logic [5:0]                controlInputs,
	// Per-rail enable requests from the pin assignment logic
	// Bit 0 of each register gates its request, whatever the pins say
	input  wire logic                      conv5PinRequest,
	input  wire logic                      conv6PinRequest,
	input  wire logic                      lin2PinRequest,
	// Voltage codes held in the voltage registers outside
	input  wire logic [RCR_CODE_WIDTH-1:0] conv5NormalVoltageCode,
	input  wire logic [RCR_CODE_WIDTH-1:0] conv5SleepVoltageCode,
	input  wire logic [RCR_CODE_WIDTH-1:0] conv6NormalVoltageCode,
	input  wire logic [RCR_CODE_WIDTH-1:0] conv6SleepVoltageCode,
	input  wire logic [RCR_CODE_WIDTH-1:0] lin2NormalVoltageCode,
	input  wire logic [RCR_CODE_WIDTH-1:0] lin2SleepVoltageCode,
	// Rail controls toward the power stages
	output logic                           conv5Enable_q,
	output logic                           conv6Enable_q,
	output logic                           lin2Enable_q,
	// Mode levels, straight from storage with no extra stage
	output logic                           conv5PwmForce,
	output logic                           conv6PwmForce,
	// Sleep flags and selected codes, registered in the rail stages
	output logic                           conv5InSleep_q,
	output logic                           conv6InSleep_q,
	output logic                           lin2InSleep_q,
	output logic [RCR_CODE_WIDTH-1:0]      conv5VoltageCode_q,
	output logic [RCR_CODE_WIDTH-1:0]      conv6VoltageCode_q,
	output logic [RCR_CODE_WIDTH-1:0]      lin2VoltageCode_q
);

	// Stored writable bits 5:0 of each register; 7:6 have no storage
	logic [RCR_STORED_WIDTH-1:0] conv5Ctrl_q; // Converter five control
	logic [RCR_STORED_WIDTH-1:0] conv5Ctrl_d;
	logic [RCR_STORED_WIDTH-1:0] conv6Ctrl_q; // Converter six control
	logic [RCR_STORED_WIDTH-1:0] conv6Ctrl_d;
	logic [RCR_STORED_WIDTH-1:0] lin2Ctrl_q;  // Linear regulator control
	logic [RCR_STORED_WIDTH-1:0] lin2Ctrl_d;

	// Address decode
	logic hitConv5; // Offset selects converter five
	logic hitConv6; // Offset selects converter six
	logic hitLin2;  // Offset selects the linear regulator

	// Write strobes qualified by the decode
	logic wrConv5; // Byte write lands in converter five
	logic wrConv6; // Byte write lands in converter six
	logic wrLin2;  // Byte write lands in the regulator

	// Read path
	logic [7:0] readMux; // Byte selected for a read
	logic [7:0] rdData_d;
	logic       rdValid_d;

	// Field views of the stored registers
	logic [1:0] conv5SleepSelect; // Sleep select of converter five
	logic [1:0] conv6SleepSelect; // Sleep select of converter six
	logic [1:0] lin2SleepSelect;  // Sleep select of the regulator
	logic       conv5RunAllow;    // Converter five may run
	logic       conv6RunAllow;    // Converter six may run
	logic       lin2RunAllow;     // Regulator may run

	// Shared by all three images so the zero top bits stand in one place
	// Widens a stored image to a full byte with the top two bits zero
	function automatic logic [7:0] readImage(input logic [RCR_STORED_WIDTH-1:0] stored);
		readImage = {2'h0, stored};
	endfunction

	// Address decode of the three fixed offsets
	assign hitConv5 = (regAddr == RCR_CONV5_OFFSET);
	assign hitConv6 = (regAddr == RCR_CONV6_OFFSET);
	assign hitLin2  = (regAddr == RCR_LIN2_OFFSET);
	// Hit is combinational so the engine can judge an offset at once,
	// before any data byte of the access is moved
	assign regHit   = hitConv5 | hitConv6 | hitLin2;

	// One strobe per register, so a stray offset never disturbs storage
	assign wrConv5 = regWrEn & hitConv5;
	assign wrConv6 = regWrEn & hitConv6;
	assign wrLin2  = regWrEn & hitLin2;

	// Writes keep bits 5:0 only; bits 7:6 of the data are dropped.
	// Reserved bits 3:2 (and 1 on the regulator) are stored as written:
	// the host is trusted to write 11 / 110 there, and to avoid the
	// reserved select codes; nothing here repairs a wrong pattern.
	// A read of the same offset in that cycle still returns the old
	// byte, since the read image comes from the flops before the edge.
	assign conv5Ctrl_d = wrConv5 ?
		regWrData[RCR_STORED_WIDTH-1:0] : conv5Ctrl_q;
	assign conv6Ctrl_d = wrConv6 ?
		regWrData[RCR_STORED_WIDTH-1:0] : conv6Ctrl_q;
	assign lin2Ctrl_d  = wrLin2 ?
		regWrData[RCR_STORED_WIDTH-1:0] : lin2Ctrl_q;

	// Register storage; reset loads the factory images
	// Reset is synchronous: the images are constants, so the bank
	// settles on the first clock in reset with no asynchronous path.
	// Bits 7:6 have no flops at all, cheaper than masking on reads.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv5Ctrl_q <= RCR_CONV5_RESET;
			conv6Ctrl_q <= RCR_CONV6_RESET;
			lin2Ctrl_q  <= RCR_LIN2_RESET;
		end else begin
			conv5Ctrl_q <= conv5Ctrl_d;
			conv6Ctrl_q <= conv6Ctrl_d;
			lin2Ctrl_q  <= lin2Ctrl_d;
		end
	end

	// Read selection; an unmapped offset answers with zero
	// Answering zero rather than refusing keeps the engine simple: it
	// always has a byte to shift out, at the cost of hiding bad offsets.
	assign readMux = hitConv5 ? readImage(conv5Ctrl_q) :
		hitConv6 ? readImage(conv6Ctrl_q) :
		hitLin2  ? readImage(lin2Ctrl_q) : RCR_UNMAPPED_DATA;
	// Data holds between reads; valid is a one-cycle echo of the strobe
	assign rdData_d  = regRdEn ? readMux : regRdData_q;
	assign rdValid_d = regRdEn;

	// Read data held until the next read so the engine may shift it out
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdData_q  <= 8'h00;
			regRdValid_q <= 1'b0;
		end else begin
			regRdData_q  <= rdData_d;
			regRdValid_q <= rdValid_d;
		end
	end

	// Field extraction
	// Reserved selects 01 and 10 pass through unchanged; the rail stage
	// treats them like 00, so a stray write never enters sleep.
	assign conv5SleepSelect = conv5Ctrl_q[RCR_SLEEP_SEL_HI:RCR_SLEEP_SEL_LO];
	assign conv6SleepSelect = conv6Ctrl_q[RCR_SLEEP_SEL_HI:RCR_SLEEP_SEL_LO];
	assign lin2SleepSelect  = lin2Ctrl_q[RCR_SLEEP_SEL_HI:RCR_SLEEP_SEL_LO];
	assign conv5RunAllow    = conv5Ctrl_q[RCR_RUN_BIT];
	assign conv6RunAllow    = conv6Ctrl_q[RCR_RUN_BIT];
	assign lin2RunAllow     = lin2Ctrl_q[RCR_RUN_BIT];

	// Mode bits go straight out: the stage reads a stored level
	assign conv5PwmForce = conv5Ctrl_q[RCR_MODE_BIT];
	assign conv6PwmForce = conv6Ctrl_q[RCR_MODE_BIT];

	// Rail stages: each sees both sleep-capable inputs and a factory
	// parameter picks one, so the pin choice cannot move at run time.
	// Each stage adds one register, which keeps the enables and codes
	// free of decode glitches at the cost of one cycle of latency
	// after any change of register, pin or code.

	// Converter five: select 00 keeps the normal code, 11 follows the pin
	rcr_rail_out #(
		.PIN_SEL (RCR_CONV5_PIN_SEL)
	) uConv5 (
		.clk           (clk),
		.rst_n         (rst_n),
		.sleepSelect   (conv5SleepSelect),
		.runAllow      (conv5RunAllow),
		.pinRequest    (conv5PinRequest),
		.sleepPinThree (controlInputs[RCR_PIN_THREE]),
		.sleepPinSix   (controlInputs[RCR_PIN_SIX]),
		.normalCode    (conv5NormalVoltageCode),
		.sleepCode     (conv5SleepVoltageCode),
		.railEnable_q  (conv5Enable_q),
		.inSleep_q     (conv5InSleep_q),
		.activeCode_q  (conv5VoltageCode_q)
	);

	// Converter six, same stage with its own factory pin
	rcr_rail_out #(
		.PIN_SEL (RCR_CONV6_PIN_SEL)
	) uConv6 (
		.clk           (clk),
		.rst_n         (rst_n),
		.sleepSelect   (conv6SleepSelect),
		.runAllow      (conv6RunAllow),
		.pinRequest    (conv6PinRequest),
		.sleepPinThree (controlInputs[RCR_PIN_THREE]),
		.sleepPinSix   (controlInputs[RCR_PIN_SIX]),
		.normalCode    (conv6NormalVoltageCode),
		.sleepCode     (conv6SleepVoltageCode),
		.railEnable_q  (conv6Enable_q),
		.inSleep_q     (conv6InSleep_q),
		.activeCode_q  (conv6VoltageCode_q)
	);

	// Linear regulator two; it has no mode bit, bit 1 is reserved
	rcr_rail_out #(
		.PIN_SEL (RCR_LIN2_PIN_SEL)
	) uLin2 (
		.clk           (clk),
		.rst_n         (rst_n),
		.sleepSelect   (lin2SleepSelect),
		.runAllow      (lin2RunAllow),
		.pinRequest    (lin2PinRequest),
		.sleepPinThree (controlInputs[RCR_PIN_THREE]),
		.sleepPinSix   (controlInputs[RCR_PIN_SIX]),
		.normalCode    (lin2NormalVoltageCode),
		.sleepCode     (lin2SleepVoltageCode),
		.railEnable_q  (lin2Enable_q),
		.inSleep_q     (lin2InSleep_q),
		.activeCode_q  (lin2VoltageCode_q)
	);

endmodule

// ===== test/rcr_host_model.sv
// Host model: issues single-byte register accesses as the I2C engine would.
// Assumes a free-running clk; each strobe lasts exactly one cycle.
`timescale 1ns/10ps
module rcr_host_model
	import rcr_pkg::*;
(
	input  wire logic clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic       regWrEn,
	output logic       regRdEn
);
	// Idle bus at time zero
	initial begin
		regAddr   = 8'h00;
		regWrData = 8'h00;
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
	end
	// One access: launch after an edge, hold through the sampling edge
	task automatic go(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk);
		#1;
		regAddr   = a;
		regWrData = d;
		regWrEn   = w;
		regRdEn   = !w;
		@(posedge clk);
		#1;
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
		regAddr   = ~a; // Released address and data never keep
		regWrData = ~d; // their last values
	endtask
	// Write; legal software never leaves reserved codes or patterns behind
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (v[5:4] != 2'h0) v[5:4] = 2'h3;
		if (a == RCR_LIN2_OFFSET) v[3:1] = 3'h6;
		else v[3:2] = 2'h3;
		go(a, v, 1'b1);
	endtask
	// Read; the answer is collected by whoever watches the valid pulse
	task automatic rd(input logic [7:0] a);
		go(a, 8'h00, 1'b0);
	endtask
endmodule

// ===== test/rcr_rail_control_monitor.sv
// Checker for the rail control bank, bound onto the top module's ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module rcr_rail_control_monitor
	import rcr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData_q,
	input wire logic regRdValid_q,
	input wire logic regHit,
	input wire logic [5:0] controlInputs,
	input wire logic conv5PinRequest,
	input wire logic conv6PinRequest,
	input wire logic lin2PinRequest,
	input wire logic [RCR_CODE_WIDTH-1:0] conv5NormalVoltageCode,
	input wire logic [RCR_CODE_WIDTH-1:0] conv5SleepVoltageCode,
	input wire logic conv5Enable_q,
	input wire logic conv6Enable_q,
	input wire logic lin2Enable_q,
	input wire logic conv5PwmForce,
	input wire logic conv6PwmForce,
	input wire logic conv5InSleep_q,
	input wire logic conv6InSleep_q,
	input wire logic lin2InSleep_q,
	input wire logic [RCR_CODE_WIDTH-1:0] conv5VoltageCode_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Request shapes used by the properties below
	sequence s_miss_read;
		regRdEn && !regHit;
	endsequence
	sequence s_wr5;
		regWrEn && regAddr == RCR_CONV5_OFFSET;
	endsequence
	sequence s_wr6;
		regWrEn && regAddr == RCR_CONV6_OFFSET;
	endsequence
	sequence s_wr2;
		regWrEn && regAddr == RCR_LIN2_OFFSET;
	endsequence
	a_hit_decode: assert property (regHit == (regAddr inside {8'h26, 8'h27, 8'h28}))
		else $error("hit decode wrong");
	a_read_answer: assert property (regRdEn |=> regRdValid_q)
		else $error("read not answered");
	a_valid_cause: assert property (regRdValid_q |-> $past(regRdEn))
		else $error("valid without read");
	a_miss_zero: assert property (s_miss_read |=> regRdData_q == 8'h00)
		else $error("unmapped read not zero");
	a_top_zero: assert property (regRdValid_q |-> regRdData_q[7:6] == 2'h0)
		else $error("top bits not zero");
	a_conv5_mode: assert property (s_wr5 |=> conv5PwmForce == $past(regWrData[1]))
		else $error("conv5 mode wrong");
	a_conv6_mode: assert property (s_wr6 |=> conv6PwmForce == $past(regWrData[1]))
		else $error("conv6 mode wrong");
	a_conv5_gate: assert property (conv5Enable_q |-> $past(conv5PinRequest))
		else $error("conv5 on without request");
	a_conv6_gate: assert property (conv6Enable_q |-> $past(conv6PinRequest))
		else $error("conv6 on without request");
	a_lin2_gate: assert property (lin2Enable_q |-> $past(lin2PinRequest))
		else $error("lin2 on without request");
	a_conv5_off: assert property (s_wr5 ##0 !regWrData[0] |=> ##1 !conv5Enable_q)
		else $error("conv5 on with run bit low");
	a_conv6_off: assert property (s_wr6 ##0 !regWrData[0] |=> ##1 !conv6Enable_q)
		else $error("conv6 on with run bit low");
	a_lin2_off: assert property (s_wr2 ##0 !regWrData[0] |=> ##1 !lin2Enable_q)
		else $error("lin2 on with run bit low");
	a_conv5_sleep: assert property (conv5InSleep_q |-> !$past(controlInputs[2]))
		else $error("conv5 sleep wrong pin");
	a_conv6_sleep: assert property (conv6InSleep_q |-> !$past(controlInputs[5]))
		else $error("conv6 sleep wrong pin");
	a_lin2_sleep: assert property (lin2InSleep_q |-> !$past(controlInputs[2]))
		else $error("lin2 sleep wrong pin");
	a_conv5_code: assert property ($past(rst_n) |-> conv5VoltageCode_q == (conv5InSleep_q ?
		$past(conv5SleepVoltageCode) : $past(conv5NormalVoltageCode)))
		else $error("conv5 code wrong");
endmodule
bind rcr_rail_control rcr_rail_control_monitor u_mon (.clk, .rst_n, .regAddr, .regWrData,
	.regWrEn, .regRdEn, .regRdData_q, .regRdValid_q, .regHit, .controlInputs,
	.conv5PinRequest, .conv6PinRequest, .lin2PinRequest, .conv5NormalVoltageCode,
	.conv5SleepVoltageCode, .conv5Enable_q, .conv6Enable_q, .lin2Enable_q, .conv5PwmForce,
	.conv6PwmForce, .conv5InSleep_q, .conv6InSleep_q, .lin2InSleep_q, .conv5VoltageCode_q);

// ===== test/rcr_rail_control_tb_top.sv
// Self-checking bench for the rail control bank with a host model.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module rcr_rail_control_tb_top
	import rcr_pkg::*;
;
	logic clk, rst_n, regWrEn, regRdEn, regRdValid_q, regHit;
	logic [7:0] regAddr, regWrData, regRdData_q, d, e;
	logic [5:0] controlInputs;
	logic [2:0] req, en, slp;
	logic [1:0] pwm, sel;
	logic [RCR_CODE_WIDTH-1:0] nc[3], sc[3], cd[3];
	logic [31:0] seed;
	logic [7:0] expQ[$]; // Expected read answers, oldest first
	logic sl;
	int fail_count, total_checks;
	rcr_host_model u_host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn));
	rcr_rail_control u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
		.regRdValid_q(regRdValid_q), .regHit(regHit), .controlInputs(controlInputs),
		.conv5PinRequest(req[0]), .conv6PinRequest(req[1]), .lin2PinRequest(req[2]),
		.conv5NormalVoltageCode(nc[0]), .conv5SleepVoltageCode(sc[0]),
		.conv6NormalVoltageCode(nc[1]), .conv6SleepVoltageCode(sc[1]),
		.lin2NormalVoltageCode(nc[2]), .lin2SleepVoltageCode(sc[2]),
		.conv5Enable_q(en[0]), .conv6Enable_q(en[1]), .lin2Enable_q(en[2]),
		.conv5PwmForce(pwm[0]), .conv6PwmForce(pwm[1]), .conv5InSleep_q(slp[0]),
		.conv6InSleep_q(slp[1]), .lin2InSleep_q(slp[2]), .conv5VoltageCode_q(cd[0]),
		.conv6VoltageCode_q(cd[1]), .lin2VoltageCode_q(cd[2]));
	// Pseudo-random source for data, codes and requests
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Single comparison point; every call counts
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Note the expected answer, then issue the read
	task automatic rq(input logic [7:0] a, input logic [7:0] x);
		expQ.push_back(x);
		u_host.rd(a);
	endtask
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Clock of 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Read answers are compared against the oldest note
	always @(posedge clk) begin
		if (regRdValid_q === 1'b1) check(regRdData_q, expQ.pop_front(), "read");
	end
	// Watchdog against a hung handshake
	initial begin
		#(40 * 2000);
		fail_count++;
		test_done();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		controlInputs = 6'h3F;
		req = 3'h7;
		seed = 32'h00014707;
		for (int i = 0; i < 3; i++) begin
			nc[i] = '0;
			sc[i] = '0;
		end
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		u_host.wr(8'h29, 8'hFF);
		rq(RCR_CONV5_OFFSET, 8'h0F);
		rq(RCR_CONV6_OFFSET, 8'h0D);
		rq(RCR_LIN2_OFFSET, 8'h0C);
		rq(8'h30, 8'h00);
		// Each rail, select off and on, each sleep pin dropped in turn
		for (int r = 0; r < 3; r++) begin
			for (int s = 0; s < 2; s++) begin
				seed = nxt(seed);
				sel = s ? 2'h3 : 2'h0;
				d = {seed[7:6], sel, seed[3:0]};
				req = seed[10:8];
				nc[r] = seed[17:11];
				sc[r] = seed[24:18];
				u_host.wr(RCR_CONV5_OFFSET + 8'(r), d);
				e = (r == 2) ? {2'h0, sel, 3'h6, d[0]} : {2'h0, sel, 2'h3, d[1:0]};
				rq(RCR_CONV5_OFFSET + 8'(r), e);
				if (r < 2) check(8'(pwm[r]), 8'(d[1]), "pwm");
				for (int p = 0; p < 2; p++) begin
					controlInputs = p ? 6'h1F : 6'h3B;
					repeat (2) @(posedge clk);
					#1;
					sl = (s == 1) && ((r == 1) == (p == 1));
					check(8'(en[r]), 8'(d[0] & req[r]), "enable");
					check(8'(slp[r]), 8'(sl), "sleep");
					check(8'(cd[r]), 8'(sl ? sc[r] : nc[r]), "code");
				end
			end
		end
		repeat (3) @(posedge clk);
		check(8'(expQ.size()), 8'h00, "pending");
		test_done();
	end
endmodule
